// File: csac_pkg.sv
// Constants, register layout and types for the chip-select access control block
package csac_pkg;
    localparam int          NUM_REGIONS      = 8;
    localparam int          DEFAULT_IDX      = 8;
    // Register indices; byte address is four times the index
    localparam logic [7:0]  BOOT_CTRL_INDEX  = 8'h6e;
    localparam logic [7:0]  REGION_BASE_INDEX = 8'h6f;
    localparam logic [7:0]  DEFAULT_CTRL_INDEX = 8'hc6;
    // Control field positions
    localparam int          WAIT_LSB         = 10;
    localparam int          BURST_BIT        = 9;
    localparam int          CORE_AA_BIT      = 8;
    localparam int          WIDTH_LSB        = 6;
    localparam int          EM_AA_BIT        = 5;
    localparam int          SETUP_BIT        = 4;
    localparam int          STORE_HOLD_BIT   = 3;
    localparam int          LOAD_HOLD_BIT    = 2;
    localparam int          STORE_GATE_BIT   = 1;
    localparam int          LOAD_GATE_BIT    = 0;
    localparam logic [15:0] CTRL_MASK        = 16'h3fff;
    localparam logic [15:0] DEFAULT_MASK     = 16'h3fec;
    // Reset values; boot auto-ack and width come from straps
    localparam logic [15:0] BOOT_RESET       = 16'h3c1f;
    localparam logic [15:0] REGION_RESET     = 16'h0000;
    localparam logic [15:0] DEFAULT_RESET    = 16'h0000;
    localparam logic [3:0]  STRAP_WAIT       = 4'hf;
    // Port width codes
    localparam logic [1:0]  WIDTH_32         = 2'h0;
    localparam logic [1:0]  WIDTH_8          = 2'h1;
    localparam logic [1:0]  WIDTH_16         = 2'h2;
    localparam logic [3:0]  LANES_32         = 4'hf;
    localparam logic [3:0]  LANES_8          = 4'h8;
    localparam logic [3:0]  LANES_16         = 4'hc;
    // Transfer size codes
    localparam logic [1:0]  SIZE_BYTE        = 2'h0;
    localparam logic [1:0]  SIZE_WORD        = 2'h1;
    localparam logic [1:0]  SIZE_LONG        = 2'h2;
    localparam logic [1:0]  SIZE_LINE        = 2'h3;
    typedef enum logic [1:0] {IDLE, SETUP, ACCESS, HOLD} state_type;
endpackage

// File: chip_select_access_control.sv
// Chip-select access control: APB register file and external transfer sequencer
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module chip_select_access_control
    import csac_pkg::*;
(
    input  wire logic        pclk,                 // System clock, 25 MHz
    input  wire logic        presetn,              // Async reset, active low
    input  wire logic        psel,                 // APB select
    input  wire logic        penable,              // APB access phase
    input  wire logic        pwrite,               // APB direction
    input  wire logic [11:0] paddr,                // APB byte address
    input  wire logic [31:0] pwdata,               // APB write data
    output logic      [31:0] prdata,               // APB read data
    output logic             pready,               // APB ready
    output logic             pslverr,              // APB error, unmapped address
    input  wire logic        boot_ack_strap,       // Boot auto-ack strap
    input  wire logic        boot_width_strap_hi,  // Boot width strap, high bit
    input  wire logic        boot_width_strap_lo,  // Boot width strap, low bit
    input  wire logic        core_req,             // Core transfer request, level
    input  wire logic        core_write,           // Core direction, 1 = store
    input  wire logic [1:0]  core_size,            // Core transfer size code
    input  wire logic [7:0]  core_hit,             // Region hits from address decode
    input  wire logic        core_dram_hit,        // Access belongs to DRAM
    input  wire logic        em_req,               // External master request, level
    input  wire logic        em_write,             // External master direction
    input  wire logic [7:0]  em_hit,               // Region hits for master address
    input  wire logic        em_dram_hit,          // Master access belongs to DRAM
    input  wire logic        transfer_ack_in_n,    // Acknowledge pin level
    input  wire logic        alt_transfer_ack_n,   // Alternate acknowledge
    input  wire logic        bus_error_ack_n,      // Error acknowledge
    output logic             transfer_ack_out_n,   // Acknowledge pin drive value
    output logic             transfer_ack_oe_n,    // Acknowledge pin enable, low drives
    output logic [7:0]       select_n,             // Region select strobes
    output logic             store_strobe_n,       // Write strobe
    output logic             addr_drive,           // Address and attributes valid
    output logic             data_drive,           // Write data valid
    output logic [3:0]       lane_en,              // Valid data byte lanes
    output logic             burst_active,         // Transfer runs as burst
    output logic             core_ack,             // Internal acknowledge pulse per beat
    output logic             core_error,           // Error termination pulse
    output logic             xfer_done             // Whole transfer finished, pulse
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [3:0] lanes_of(input logic [1:0] width);
        unique case (width)
            WIDTH_32: lanes_of = LANES_32;
            WIDTH_8:  lanes_of = LANES_8;
            default:  lanes_of = LANES_16;
        endcase
    endfunction

    function automatic logic [3:0] bytes_of_size(input logic [1:0] size);
        unique case (size)
            SIZE_BYTE: bytes_of_size = 4'h1;
            SIZE_WORD: bytes_of_size = 4'h2;
            SIZE_LONG: bytes_of_size = 4'h4;
            default:   bytes_of_size = 4'h8;
        endcase
    endfunction

    // Beats needed; a line is four longwords, counted in port units
    function automatic logic [4:0] beats_of(input logic [1:0] size, input logic [1:0] width);
        logic [4:0] b;
        b = (size == SIZE_LINE) ? 5'h10 : {1'b0, bytes_of_size(size)};
        unique case (width)
            WIDTH_32: beats_of = (b > 5'h4) ? (b >> 2) : 5'h1;
            WIDTH_8:  beats_of = b;
            default:  beats_of = (b > 5'h2) ? (b >> 1) : 5'h1;
        endcase
    endfunction

    function automatic logic [3:0] hit_index(input logic [7:0] hit);
        hit_index = 4'(DEFAULT_IDX);
        for (int i = NUM_REGIONS - 1; i >= 0; i--) begin
            if (hit[i]) begin
                hit_index = 4'(i);
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register file

    logic [15:0] ctrl [0:NUM_REGIONS];
    logic [2:0]  strap;
    logic        strap_loaded;

    wire  [9:0]  reg_index  = paddr[11:2];
    wire         word_ok    = (paddr[1:0] == 2'h0);
    wire         is_boot    = word_ok && reg_index == {2'h0, BOOT_CTRL_INDEX};
    wire         is_default = word_ok && reg_index == {2'h0, DEFAULT_CTRL_INDEX};
    wire  [9:0]  region_off = reg_index - {2'h0, REGION_BASE_INDEX};
    wire         is_region  = word_ok && region_off >= 10'h1 && region_off <= 10'h7;
    wire  [3:0]  sel_idx    = is_boot ? 4'h0 : (is_default ? 4'(DEFAULT_IDX) : region_off[3:0]);
    wire         mapped     = is_boot || is_default || is_region;
    wire         setup_ph   = psel && !penable;
    wire         wr_take    = psel && penable && pready && pwrite && mapped;
    wire  [15:0] wr_mask    = is_default ? DEFAULT_MASK : CTRL_MASK;

    // No reset here on purpose: keeps the last level seen while reset is low
    always_ff @(posedge pclk) begin
        if (!presetn) begin
            strap <= {boot_ack_strap, boot_width_strap_hi, boot_width_strap_lo};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl[0] <= BOOT_RESET;
            for (int i = 1; i < NUM_REGIONS; i++) begin
                ctrl[i] <= REGION_RESET;
            end
            ctrl[DEFAULT_IDX] <= DEFAULT_RESET;
            strap_loaded <= 1'b0;
        end else begin
            strap_loaded <= 1'b1;
            if (!strap_loaded) begin
                ctrl[0][CORE_AA_BIT] <= strap[2];
                ctrl[0][WAIT_LSB +: 4] <= STRAP_WAIT;
                ctrl[0][WIDTH_LSB +: 2] <= {strap[1], strap[1] ? 1'b0 : strap[0]};
            end else if (wr_take) begin
                ctrl[sel_idx] <= pwdata[15:0] & wr_mask;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // Answer prepared in the setup cycle, so access completes at once
            pready  <= setup_ph;
            pslverr <= setup_ph && !mapped;
            prdata  <= (setup_ph && mapped) ? {16'h0000, ctrl[sel_idx]} : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transfer sequencer

    state_type   state;
    state_type   next_state;
    logic [3:0]  cur_idx;
    logic [15:0] cur_cfg;
    logic        cur_em;
    logic        cur_write;
    logic [4:0]  beats_left;
    logic [3:0]  wait_cnt;
    logic        first_cycle;

    wire         take_em    = em_req && !em_dram_hit;
    wire         take_core  = core_req && !core_dram_hit && !take_em;
    wire         start      = (state == IDLE) && (take_em || take_core);
    wire  [3:0]  start_idx  = take_em ? hit_index(em_hit) : hit_index(core_hit);
    wire         start_wr   = take_em ? em_write : core_write;
    wire  [15:0] start_cfg  = ctrl[start_idx];
    wire         start_def  = start_idx == 4'(DEFAULT_IDX);
    // Default space has no setup delay field
    wire         start_addr_setup_delay = !start_def && start_cfg[SETUP_BIT];

    wire  [3:0]  ws         = cur_cfg[WAIT_LSB +: 4];
    wire         cur_def    = cur_idx == 4'(DEFAULT_IDX);
    wire         cur_addr_setup_delay   = !cur_def && cur_cfg[SETUP_BIT];
    wire         gate_ok    = !cur_def && (cur_write ? cur_cfg[STORE_GATE_BIT]
                                                     : cur_cfg[LOAD_GATE_BIT]);
    wire         em_auto    = cur_em && cur_cfg[EM_AA_BIT];
    wire         core_auto  = !cur_em && cur_cfg[CORE_AA_BIT];
    wire         burst_ok   = cur_cfg[BURST_BIT];
    wire         hold_req   = cur_write ? cur_cfg[STORE_HOLD_BIT] : cur_cfg[LOAD_HOLD_BIT];
    wire         ext_term   = !transfer_ack_in_n || !alt_transfer_ack_n;
    wire         err_term   = !bus_error_ack_n;
    wire         waits_done = wait_cnt == ws;
    // Own drive terminates a master cycle with auto-ack; the pin is not sampled then
    wire         term_ok    = em_auto ? !transfer_ack_out_n
                            : (core_auto ? (waits_done || ext_term)
                                         : ext_term);
    wire         in_access  = state == ACCESS;
    wire         term       = in_access && (term_ok || err_term);
    wire         more       = term && !err_term && beats_left > 5'h1;
    wire         burst_next = more && burst_ok;
    wire         last_term  = term && !more;

    always_comb begin
        next_state = state;
        unique case (state)
            IDLE: begin
                if (start) begin
                    next_state = start_addr_setup_delay ? SETUP : ACCESS;
                end
            end
            SETUP: begin
                next_state = ACCESS;
            end
            ACCESS: begin
                if (burst_next) begin
                    next_state = ACCESS;
                end else if (more || (last_term && hold_req)) begin
                    next_state = HOLD;
                end else if (last_term) begin
                    next_state = IDLE;
                end
            end
            HOLD: begin
                if (beats_left != 5'h0) begin
                    next_state = cur_addr_setup_delay ? SETUP : ACCESS;
                end else begin
                    next_state = IDLE;
                end
            end
        endcase
    end

    wire entering_access = next_state == ACCESS && (state != ACCESS || burst_next);
    wire fresh_access    = next_state == ACCESS && state != ACCESS;
    wire leaving         = next_state == IDLE && state != IDLE;
    wire start_lanes_en  = 1'b1;

    // Look one cycle ahead: the latched config is stale on the start edge
    wire         next_em_auto  = start ? (take_em && start_cfg[EM_AA_BIT]) : em_auto;
    wire  [3:0]  next_ws       = start ? start_cfg[WAIT_LSB +: 4] : ws;
    wire  [3:0]  next_wait     = entering_access ? 4'h0 : ((in_access && !waits_done) ? wait_cnt + 4'h1 : wait_cnt);
    wire         next_em_drive = next_em_auto && next_state == ACCESS;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= IDLE;
            cur_idx     <= 4'(DEFAULT_IDX);
            cur_cfg     <= 16'h0000;
            cur_em      <= 1'b0;
            cur_write   <= 1'b0;
            beats_left  <= 5'h0;
            wait_cnt    <= 4'h0;
            first_cycle <= 1'b0;
        end else begin
            state <= next_state;
            if (start) begin
                cur_idx    <= start_idx;
                cur_cfg    <= start_cfg;
                cur_em     <= take_em;
                cur_write  <= start_wr;
                beats_left <= take_em ? 5'h1 : beats_of(core_size, start_cfg[WIDTH_LSB +: 2]);
            end else if (term) begin
                beats_left <= err_term ? 5'h0 : beats_left - 5'h1;
            end
            if (entering_access) begin
                wait_cnt <= 4'h0;
            end else if (in_access && !waits_done) begin
                wait_cnt <= wait_cnt + 4'h1;
            end
            first_cycle <= fresh_access;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive, all from flops

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select_n           <= 8'hff;
            store_strobe_n     <= 1'b1;
            addr_drive         <= 1'b0;
            data_drive         <= 1'b0;
            lane_en            <= 4'h0;
            burst_active       <= 1'b0;
            transfer_ack_out_n <= 1'b1;
            transfer_ack_oe_n  <= 1'b1;
            core_ack           <= 1'b0;
            core_error         <= 1'b0;
            xfer_done          <= 1'b0;
        end else begin
            // Address valid from start until the transfer (and any hold) is over
            if (start && start_lanes_en) begin
                addr_drive <= 1'b1;
                data_drive <= start_wr;
                lane_en    <= lanes_of(start_cfg[WIDTH_LSB +: 2]);
            end else if (leaving) begin
                addr_drive <= 1'b0;
                data_drive <= 1'b0;
                lane_en    <= 4'h0;
            end
            // Select asserts with the address, or one cycle later under setup delay
            if (start && !start_addr_setup_delay && !start_def) begin
                select_n <= ~(8'h01 << start_idx[2:0]) | {8{!(start_wr ? start_cfg[STORE_GATE_BIT]
                                                                       : start_cfg[LOAD_GATE_BIT])}};
            end else if (fresh_access && state != IDLE && gate_ok) begin
                select_n <= ~(8'h01 << cur_idx[2:0]);
            end else if (term && !burst_next) begin
                select_n <= 8'hff;
            end
            // Store strobe one clock behind select
            if (first_cycle && !term && cur_write && gate_ok) begin
                store_strobe_n <= 1'b0;
            end else if (term && !burst_next) begin
                store_strobe_n <= 1'b1;
            end
            burst_active <= burst_next || (burst_active && in_access && !last_term);
            // Acknowledge pin driven only for master cycles with auto-ack
            // Ack lands in the access cycle after the programmed waits, as for the core
            transfer_ack_oe_n  <= !next_em_drive;
            transfer_ack_out_n <= !(next_em_drive && next_wait == next_ws);
            core_ack   <= term && !cur_em && !err_term;
            core_error <= term && err_term;
            xfer_done  <= leaving;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    logic [4:0] access_len;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            access_len <= 5'h0;
        end else begin
            access_len <= entering_access ? 5'h0 : (in_access ? access_len + 5'h1 : access_len);
        end
    end

    a_auto_ack_waits: assert property (
        @(posedge pclk) disable iff (!presetn)
        (in_access && core_auto && !ext_term && !err_term && access_len == {1'b0, ws}) |-> ##1 core_ack)
        else $error("core auto-ack did not follow programmed waits");

    a_no_early_ack: assert property (
        @(posedge pclk) disable iff (!presetn)
        (in_access && !cur_em && !core_auto && transfer_ack_in_n && alt_transfer_ack_n) |-> ##1 !core_ack)
        else $error("core acknowledged without external acknowledge");

    a_master_ack_drive: assert property (
        @(posedge pclk) disable iff (!presetn)
        !transfer_ack_out_n |-> !transfer_ack_oe_n && cur_em && cur_cfg[EM_AA_BIT])
        else $error("acknowledge asserted without driving it");

    a_master_ack_idle: assert property (
        @(posedge pclk) disable iff (!presetn)
        (in_access && cur_em && !cur_cfg[EM_AA_BIT]) |-> transfer_ack_oe_n)
        else $error("acknowledge driven with master auto-ack clear");

    a_setup_delay: assert property (
        @(posedge pclk) disable iff (!presetn)
        (start && start_addr_setup_delay) |=> addr_drive && select_n == 8'hff)
        else $error("select asserted during setup delay");

    a_store_after_sel: assert property (
        @(posedge pclk) disable iff (!presetn)
        $fell(store_strobe_n) |-> $past(select_n) != 8'hff)
        else $error("store strobe ahead of select");

    a_lane_width: assert property (
        @(posedge pclk) disable iff (!presetn)
        (in_access && cur_cfg[WIDTH_LSB +: 2] == WIDTH_8) |-> lane_en == LANES_8)
        else $error("byte lanes do not match port width");

    a_hold_cycle: assert property (
        @(posedge pclk) disable iff (!presetn)
        (last_term && hold_req) |=> addr_drive && select_n == 8'hff ##1 !addr_drive || state != IDLE)
        else $error("address hold cycle missing");

    a_default_no_sel: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state != IDLE && cur_def) |-> select_n == 8'hff)
        else $error("select asserted for default space");

    a_gate_block: assert property (
        @(posedge pclk) disable iff (!presetn)
        (in_access && !cur_write && !cur_def && !cur_cfg[LOAD_GATE_BIT]) |-> select_n == 8'hff)
        else $error("select asserted on read with load gate clear");

endmodule

// File: csac_responder.sv
// External responder model: late acknowledge onto a pulled-up pin
`timescale 1ns/1ps
module csac_responder (
    input  wire logic       pclk,       // System clock
    input  wire logic [7:0] select_n,   // Region selects from the device
    input  wire logic       drive_oe_n, // Low while the device drives the pin
    input  wire logic [3:0] delay,      // Cycles selected before answering, 0 = silent
    output logic            ack_n       // Our drive, pull-up level when silent
);
    logic [3:0] cnt = 4'h0;
    // Never answers while the device owns the pin
    assign ack_n = !(delay != 4'h0 && cnt == delay && drive_oe_n);
    always_ff @(posedge pclk) begin
        if (&select_n || cnt == delay) begin
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// File: chip_select_access_control_tb.sv
// Bench for the chip-select access control block
`timescale 1ns/1ps
module chip_select_access_control_tb;
    import csac_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        strap_aa = 1'b1, strap_hi = 1'b0, strap_lo = 1'b1, core_req = 1'b0, em_req = 1'b0;
    logic        wr_dir = 1'b0, pready, pslverr, err, ack_pin, resp_ack_n, ack_out_n, ack_oe_n;
    logic        burst_active, core_ack, xfer_done, addr_drive, store_n, data_drv, core_err, tea_n = 1'b1;
    logic [1:0]  core_size = 2'h2;
    logic [3:0]  resp_delay = 4'h0, lane_en, lanes;
    logic [7:0]  hit = 8'h02, select_n;
    int          miscompares = 0, num_checks = 0, acks, sels, oes, bursts, strobes, datas, gaps, errs;
    chip_select_access_control u_chip_select_access_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .boot_ack_strap(strap_aa),
        .boot_width_strap_hi(strap_hi), .boot_width_strap_lo(strap_lo), .core_req(core_req),
        .core_write(wr_dir), .core_size(core_size), .core_hit(hit), .core_dram_hit(1'b0), .em_req(em_req),
        .em_write(wr_dir), .em_hit(hit), .em_dram_hit(1'b0), .transfer_ack_in_n(ack_pin),
        .alt_transfer_ack_n(1'b1), .bus_error_ack_n(tea_n), .transfer_ack_out_n(ack_out_n),
        .transfer_ack_oe_n(ack_oe_n), .select_n(select_n), .store_strobe_n(store_n), .addr_drive(addr_drive),
        .data_drive(data_drv), .lane_en(lane_en), .burst_active(burst_active), .core_ack(core_ack),
        .core_error(core_err), .xfer_done(xfer_done));
    csac_responder u_csac_responder (.pclk(pclk), .select_n(select_n), .drive_oe_n(ack_oe_n),
        .delay(resp_delay), .ack_n(resp_ack_n));
    assign ack_pin = ack_oe_n ? resp_ack_n : ack_out_n;
    initial forever #20 pclk = ~pclk;
    ////////////////////////////////////////
    task automatic print_verdict;
        if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bound(input int n);
        if (n >= 200) begin
            miscompares++;
            print_verdict();
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 200);
        bound(n);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Drop the request once done is seen, then drain any restart it caused
    task automatic xfer(input logic em, input logic w);
        int n = 0;
        acks = 0;
        sels = 0;
        oes = 0;
        bursts = 0;
        strobes = 0;
        datas = 0;
        gaps = 0;
        errs = 0;
        @(posedge pclk);
        core_req <= !em;
        em_req <= em;
        wr_dir <= w;
        do begin
            @(posedge pclk);
            n++;
            if (core_ack === 1'b1 || ack_out_n === 1'b0) acks++;
            if (select_n !== 8'hff) sels++;
            if (ack_oe_n === 1'b0) oes++;
            if (burst_active === 1'b1) bursts++;
            if (addr_drive === 1'b1) lanes = lane_en;
            if (store_n === 1'b0) strobes++;
            if (data_drv === 1'b1) datas++;
            if (addr_drive === 1'b1 && select_n === 8'hff) gaps++;
            if (core_err === 1'b1) errs++;
        end while (xfer_done !== 1'b1 && n < 200);
        bound(n);
        core_req <= 1'b0;
        em_req <= 1'b0;
        @(posedge pclk);
        for (n = 0; addr_drive === 1'b1 && n < 200; n++) @(posedge pclk);
        bound(n);
    endtask
    ////////////////////////////////////////
    task automatic check_reset;
        apb(1'b0, 12'h1b8, 32'h0);
        chk(rd, 32'h0000_3d5f);
        apb(1'b0, 12'h1c0, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic check_acks;
        apb(1'b1, 12'h1c0, 32'h0903);
        xfer(1'b0, 1'b0);
        chk(acks, 1);
        chk(sels, 3);
        chk(lanes, LANES_32);
        resp_delay <= 4'h2;
        apb(1'b1, 12'h1c0, 32'h3d03);
        xfer(1'b0, 1'b0);
        chk(sels < 16, 1);
        apb(1'b1, 12'h1c0, 32'h0003);
        xfer(1'b0, 1'b0);
        chk(acks, 1);
        xfer(1'b1, 1'b0);
        chk(oes, 0);
        resp_delay <= 4'h0;
        apb(1'b1, 12'h1c0, 32'h0823);
        xfer(1'b1, 1'b0);
        chk(acks, 1);
        chk(oes, 3);
    endtask
    task automatic check_split_burst;
        apb(1'b1, 12'h1c0, 32'h0143);
        xfer(1'b0, 1'b1);
        chk(acks, 4);
        chk(bursts, 0);
        chk(lanes, LANES_8);
        apb(1'b1, 12'h1c0, 32'h0343);
        xfer(1'b0, 1'b1);
        chk(acks, 4);
        chk(bursts > 0, 1);
    endtask
    task automatic check_gates;
        apb(1'b1, 12'h1c0, 32'h0102);
        xfer(1'b0, 1'b0);
        chk(sels, 0);
        xfer(1'b0, 1'b1);
        chk(sels > 0, 1);
        apb(1'b1, 12'h1c0, 32'h0101);
        xfer(1'b0, 1'b1);
        chk(sels, 0);
    endtask
    // Setup delay and hold cycles show as address-valid cycles with select high
    task automatic check_setup_hold;
        apb(1'b1, 12'h1c0, 32'h051b);
        xfer(1'b0, 1'b1);
        chk(gaps, 2);
        chk(sels, 2);
        chk(strobes, 1);
        chk(datas, 4);
        apb(1'b1, 12'h1c0, 32'h0507);
        xfer(1'b0, 1'b0);
        chk(gaps, 1);
        chk(strobes, 0);
        apb(1'b1, 12'h1c0, 32'h0003);
        tea_n <= 1'b0;
        xfer(1'b0, 1'b0);
        chk(errs, 1);
        chk(acks, 0);
        tea_n <= 1'b1;
    endtask
    task automatic check_default;
        apb(1'b0, 12'h318, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h318, 32'hffff);
        apb(1'b0, 12'h318, 32'h0);
        chk(rd, 32'h3fec);
        apb(1'b0, 12'h004, 32'h0);
        chk(err, 1'b1);
        hit <= 8'h00;
        xfer(1'b0, 1'b0);
        chk(acks, 2);
        chk(sels, 0);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        strap_aa <= 1'b0;
        strap_lo <= 1'b0;
        @(posedge pclk);
        check_reset();
        check_acks();
        check_split_burst();
        check_gates();
        check_setup_hold();
        check_default();
        print_verdict();
    end
endmodule
